//--- hdl/ster_regs.vh
// Constants for the SCSI target exception response block.
// Assumes APB byte addressing with one 32-bit word per register.
// Operation
// - Async target transfer-out parity error drops the byte and sets the parity fault flag.
// - DMA parity error as master: drop byte, drop one more strobe, set flag.
// - DMA parity error as slave: drop byte, negate DMA request, ignore writes, flag.
// - Sync parity error keeps counting ACK pulses for offset, stores no data.
// - Attention flag set clears and locks high-level registers and sequencer address writes.
// - Attention flag rising edge halts a running sequencer before its stop/jump test.
// - Idle sequencer: ATN assertion edge sets attention flag; ATN already high does nothing.
// - Attention disabled ignores ATN edge and level while running (idle edge still flags); hard-halt bit has no effect.
// - Non-data phase or no hard halt: sample ATN at instruction end, flag if set.
// - Hard halt in data phase samples ATN at each ACK negation edge.
// - Async FIFO transfer-in halt stops DMA requests, waits FIFO empty, then flags.
// - Sync FIFO transfer-in halt keeps REQ until FIFO empty, waits ACKs, then flags.
// - Dual-port halt stops REQ at once; sync mode waits for ACKs, then flags.
// - Async FIFO transfer-out halt stops REQ, waits FIFO empty; processor drains without DMA.
// - Sync transfer-out halt stops REQ, waits ACKs, drains to DMA or dual-port, flags.
// - Soft halt keeps handshaking with the initiator without moving real data.
// - Sequencer and pipe events set flag, lock registers; interrupt saves address; stop halts.
// - Count overrun finishes FIFO transfer unshifted, clears busy states, halts, flags, locks.
// - Link fault events flag, halt transfer, lock, halt sequencer; timeout tristates outputs; selection rejected only flags and locks.
// - Bus reset flags, clears registers, signals unless masked, tristates, halts DMA and sequencer.
// - Parity fault flag locks registers; its rising edge halts a running sequencer.
`ifndef STER_REGS_VH
`define STER_REGS_VH
`define STER_OFS_CTRL      8'h00
`define STER_OFS_STATUS    8'h04
`define STER_OFS_STOPADDR  8'h08
`define STER_OFS_STATE     8'h0C
`define STER_OFS_COUNTCTL  8'h10
`define STER_CTRL_RESET    4'h0
`define STER_CTRL_ATN_EN   0
`define STER_CTRL_HARD     1
`define STER_CTRL_SOFT     2
`define STER_CTRL_RSTMASK  3
`define STER_CNT_LOAD      0
`define STER_CNT_LATCH     1
`define STER_NFLAGS        18
`define STER_FLAGS_RESET   18'h00000
`define STER_F_PARITY      0
`define STER_F_ATTN        1
`define STER_F_SEQIRQ      2
`define STER_F_SEQSTOP     3
`define STER_F_BUSY        4
`define STER_F_VERY_BUSY_STATE       5
`define STER_F_OVERRUN     6
`define STER_F_TIMEOUT     7
`define STER_F_UPHASE      14
`define STER_F_BUSRST      15
`define STER_F_SELECTION_REJECTED        16
`define STER_F_UNEXPECTED_DISCONNECT       17
`define STER_FAULT_MASK    18'h27F80
`define STER_SQA_LOCK_MASK 18'h37FFF
`endif

//--- hdl/ster_attn_halt.v
// Attention halt sequencer for target transfers.
// Assumes synchronised ATN level and one-cycle ACK negation pulses on pclk.
`timescale 1ns/1ps
module ster_attn_halt (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       atn,
  input  wire       ack_neg,
  input  wire       seq_running,
  input  wire       instr_end,
  input  wire       data_phase,
  input  wire       attention_enable,
  input  wire       attention_hard_halt,
  input  wire       attention_soft_halt,
  input  wire       attention_irq,
  input  wire       xfer_out,
  input  wire       sync_mode,
  input  wire       fifo_xfer,
  input  wire       fifo_empty,
  input  wire       acks_done,
  output reg        attn_set,
  output reg        req_stop,
  output reg        dma_stop,
  output reg        drain_dma,
  output reg        dpr_store,
  output reg        soft_active,
  output reg  [1:0] state
);
  localparam S_IDLE  = 2'b00;
  localparam S_FIFO  = 2'b01;
  localparam S_ACK   = 2'b10;
  localparam S_DRAIN = 2'b11;

  reg       atn_q;
  reg [1:0] next_state;
  reg       next_set;
  reg       next_dpr;
  wire      atn_rise = atn & ~atn_q;
  wire      hard     = attention_enable & attention_hard_halt & data_phase;
  wire      hit      = hard & ack_neg & atn & ~attention_irq;

  always @* begin
    next_state = state;
    next_set   = 1'b0;
    next_dpr   = 1'b0;
    case (state)
      S_IDLE: begin
        if (!seq_running)
          next_set = atn_rise;
        else if (attention_enable && !hard && instr_end)
          next_set = atn;
        else if (hit) begin
          if (fifo_xfer && !(xfer_out && sync_mode))
            next_state = S_FIFO;
          else if (sync_mode)
            next_state = S_ACK;
          else
            next_set = 1'b1;
        end
      end
      S_FIFO: begin
        if (fifo_empty) begin
          if (sync_mode)
            next_state = S_ACK;
          else begin
            next_state = S_IDLE;
            next_set   = 1'b1;
          end
        end
      end
      S_ACK: begin
        if (acks_done) begin
          if (xfer_out && fifo_xfer)
            next_state = S_DRAIN;
          else begin
            next_state = S_IDLE;
            next_set   = 1'b1;
            next_dpr   = xfer_out;
          end
        end
      end
      S_DRAIN: begin
        if (fifo_empty) begin
          next_state = S_IDLE;
          next_set   = 1'b1;
        end
      end
      default: next_state = S_IDLE;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state       <= S_IDLE;
      atn_q       <= 1'b0;
      attn_set    <= 1'b0;
      req_stop    <= 1'b0;
      dma_stop    <= 1'b0;
      drain_dma   <= 1'b0;
      dpr_store   <= 1'b0;
      soft_active <= 1'b0;
    end else begin
      state     <= next_state;
      atn_q     <= atn;
      attn_set  <= next_set;
      dpr_store <= next_dpr;
      // Sync FIFO transfer-in must keep pulsing REQ to drain the FIFO
      // REQ stays stopped until software clears the attention flag
      req_stop  <= ((next_state != S_IDLE) &&
                    !(next_state == S_FIFO && sync_mode && !xfer_out)) ||
                   (seq_running && hit && !fifo_xfer && !sync_mode) ||
                   (req_stop && (next_set || attn_set || attention_irq));
      dma_stop  <= (next_state != S_IDLE) && !xfer_out;
      drain_dma <= (next_state == S_DRAIN);
      // Soft halt keeps the protocol alive without real data
      if (!seq_running || !data_phase)
        soft_active <= 1'b0;
      else if (attention_enable && attention_soft_halt && !attention_hard_halt && ack_neg && atn)
        soft_active <= 1'b1;
    end
  end
endmodule // ster_attn_halt

//--- hdl/ster_exception.v
// SCSI target exception response: parity, attention and event handling.
// Assumes event inputs are one-cycle pulses on pclk; SCSI pins are asynchronous.
//
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "ster_regs.vh"
module ster_exception (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        scsi_atn_pin,
  input  wire        scsi_ack_pin,
  input  wire        scsi_rst_pin,
  input  wire        byte_strobe,
  input  wire        scsi_parity_err,
  input  wire        dma_parity_err,
  input  wire        dma_master,
  input  wire        xfer_out,
  input  wire        sync_mode,
  input  wire        fifo_xfer,
  input  wire        data_phase,
  input  wire        fifo_empty,
  input  wire        req_pulse,
  input  wire        seq_running,
  input  wire        instr_end,
  input  wire [7:0]  sequencer_address,
  input  wire        sequencer_irq_event,
  input  wire        stop_sequencer_event,
  input  wire        pipe_busy_event,
  input  wire        pipe_very_busy_event,
  input  wire        count_overrun,
  input  wire        bus_timeout_fault,
  input  wire        link_check_error,
  input  wire        count_underrun,
  input  wire        offset_error,
  input  wire        queue_error,
  input  wire        unexpected_selection,
  input  wire        unexpected_reselection,
  input  wire        unexpected_phase,
  input  wire        selection_rejected,
  input  wire        unexpected_disconnect,
  input  wire        fifo_xfer_active,
  input  wire        count_zero,
  output reg         fifo_store,
  output reg         dma_request_en,
  output wire        req_stop,
  output wire        dma_stop,
  output wire        drain_dma,
  output wire        dpr_store,
  output reg         high_level_regs_clear,
  output reg         high_level_regs_lock,
  output reg         sequencer_address_lock,
  output reg         low_level_regs_clear,
  output reg         seq_halt,
  output reg         xfer_halt,
  output reg         dma_halt,
  output reg         scsi_tristate,
  output reg         busy_clear,
  output reg         pipe_shift_block,
  output reg         pipe_flush,
  output reg         irq_out,
  output reg         reset_flag_out
);
  reg  [2:0]               atn_sync;
  reg  [2:0]               ack_sync;
  reg  [2:0]               rst_sync;
  reg  [3:0]               ctrl;
  reg  [`STER_NFLAGS-1:0]  flags;
  reg  [`STER_NFLAGS-1:0]  flags_q;
  reg  [7:0]               sequencer_stop_address;
  reg  [7:0]               offset_count;
  reg                      dma_slave_block;
  reg  [`STER_NFLAGS-1:0]  ev;
  reg  [31:0]              next_rdata;
  reg                      next_err;

  wire [1:0]               halt_state;
  wire                     attn_set;
  wire                     soft_active;
  wire                     atn_s    = atn_sync[1];
  wire                     ack_neg  = ack_sync[2] & ~ack_sync[1];
  wire                     rst_rise = rst_sync[1] & ~rst_sync[2];
  wire                     acc      = psel & penable & pready;
  wire                     wr       = acc & pwrite;
  wire [`STER_NFLAGS-1:0]  clr      = (wr && paddr == `STER_OFS_STATUS) ?
                                      pwdata[`STER_NFLAGS-1:0] : {`STER_NFLAGS{1'b0}};
  wire                     parity_ev = byte_strobe & (scsi_parity_err | dma_parity_err);
  wire                     parity_fault_flag      = flags[`STER_F_PARITY];
  wire                     parity_fault_flag_rise = parity_fault_flag & ~flags_q[`STER_F_PARITY];
  wire                     atn_rise  = flags[`STER_F_ATTN] & ~flags_q[`STER_F_ATTN];
  wire                     fault_any = |(ev & `STER_FAULT_MASK);
  wire                     halt_any;
  wire                     acks_done = (offset_count == 8'h00);

  ster_attn_halt u_attn (
    .pclk                (pclk),
    .presetn             (presetn),
    .atn                 (atn_s),
    .ack_neg             (ack_neg),
    .seq_running         (seq_running),
    .instr_end           (instr_end),
    .data_phase          (data_phase),
    .attention_enable    (ctrl[`STER_CTRL_ATN_EN]),
    .attention_hard_halt (ctrl[`STER_CTRL_HARD]),
    .attention_soft_halt (ctrl[`STER_CTRL_SOFT]),
    .attention_irq       (flags[`STER_F_ATTN]),
    .xfer_out            (xfer_out),
    .sync_mode           (sync_mode),
    .fifo_xfer           (fifo_xfer),
    .fifo_empty          (fifo_empty),
    .acks_done           (acks_done),
    .attn_set            (attn_set),
    .req_stop            (req_stop),
    .dma_stop            (dma_stop),
    .drain_dma           (drain_dma),
    .dpr_store           (dpr_store),
    .soft_active         (soft_active),
    .state               (halt_state)
  );

  // Event vector in status bit order
  always @* begin
    ev                            = {`STER_NFLAGS{1'b0}};
    ev[`STER_F_PARITY]            = parity_ev;
    ev[`STER_F_ATTN]              = attn_set;
    ev[`STER_F_SEQIRQ]            = sequencer_irq_event;
    ev[`STER_F_SEQSTOP]           = stop_sequencer_event;
    ev[`STER_F_BUSY]              = pipe_busy_event;
    ev[`STER_F_VERY_BUSY_STATE]             = pipe_very_busy_event;
    ev[`STER_F_OVERRUN]           = count_overrun;
    ev[`STER_F_UPHASE:`STER_F_TIMEOUT] = {unexpected_phase, unexpected_reselection,
                                          unexpected_selection, queue_error, offset_error,
                                          count_underrun, link_check_error,
                                          bus_timeout_fault};
    ev[`STER_F_BUSRST]            = rst_rise;
    ev[`STER_F_SELECTION_REJECTED]              = selection_rejected;
    ev[`STER_F_UNEXPECTED_DISCONNECT]             = unexpected_disconnect;
  end

  assign halt_any = parity_fault_flag_rise | atn_rise | stop_sequencer_event | count_overrun |
                    fault_any | rst_rise;

  // Pins pass two flops before use; the third stage only feeds edge detection
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      atn_sync <= 3'b000;
      ack_sync <= 3'b000;
      rst_sync <= 3'b000;
    end else begin
      atn_sync <= {atn_sync[1:0], scsi_atn_pin};
      ack_sync <= {ack_sync[1:0], scsi_ack_pin};
      rst_sync <= {rst_sync[1:0], scsi_rst_pin};
    end
  end

  // Sticky flags: a new event in the clearing cycle survives
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags   <= `STER_FLAGS_RESET;
      flags_q <= `STER_FLAGS_RESET;
    end else begin
      flags   <= (flags & ~clr) | ev;
      flags_q <= flags;
    end
  end

  // REQ/ACK offset tracking runs even while data is being discarded
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      offset_count <= 8'h00;
    else if (rst_rise || unexpected_disconnect)
      offset_count <= 8'h00;
    else if (req_pulse && !ack_neg)
      offset_count <= offset_count + 8'h01;
    else if (ack_neg && !req_pulse && offset_count != 8'h00)
      offset_count <= offset_count - 8'h01;
  end

  // Data path gating on parity faults
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_store      <= 1'b0;
      dma_request_en  <= 1'b0;
      dma_slave_block <= 1'b0;
    end else begin
      // While the flag stands every later byte is dropped, covering the extra read strobe
      fifo_store <= byte_strobe & ~scsi_parity_err & ~dma_parity_err &
                    ~parity_fault_flag & ~soft_active;
      if (!parity_fault_flag && !parity_ev)
        dma_slave_block <= 1'b0;
      else if (byte_strobe && dma_parity_err && !dma_master)
        dma_slave_block <= 1'b1;
      dma_request_en <= ~dma_master & ~dma_stop & ~flags[`STER_F_BUSRST] &
                        ~(byte_strobe & dma_parity_err) & ~dma_slave_block;
    end
  end

  // Register locks, halts and bus-level reactions
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_level_regs_clear  <= 1'b0;
      high_level_regs_lock   <= 1'b0;
      sequencer_address_lock <= 1'b0;
      low_level_regs_clear   <= 1'b0;
      seq_halt               <= 1'b0;
      xfer_halt              <= 1'b0;
      dma_halt               <= 1'b0;
      scsi_tristate          <= 1'b0;
      busy_clear             <= 1'b0;
      pipe_shift_block       <= 1'b0;
      irq_out                <= 1'b0;
      reset_flag_out         <= 1'b0;
      sequencer_stop_address <= 8'h00;
    end else begin
      // Any standing flag keeps the high-level registers cleared and locked
      high_level_regs_clear  <= |flags;
      high_level_regs_lock   <= |flags;
      sequencer_address_lock <= |(flags & `STER_SQA_LOCK_MASK);
      low_level_regs_clear   <= rst_rise | unexpected_disconnect;
      seq_halt   <= seq_running & halt_any;
      xfer_halt  <= fault_any;
      dma_halt   <= rst_rise;
      scsi_tristate <= flags[`STER_F_TIMEOUT] | flags[`STER_F_BUSRST] |
                       flags[`STER_F_UNEXPECTED_DISCONNECT];
      busy_clear <= count_overrun;
      // Overrun lets the FIFO run down to zero without moving the pipe
      pipe_shift_block <= flags[`STER_F_OVERRUN] & fifo_xfer_active & ~count_zero;
      irq_out        <= flags[`STER_F_BUSRST] & ~ctrl[`STER_CTRL_RSTMASK];
      reset_flag_out <= flags[`STER_F_BUSRST] & ~ctrl[`STER_CTRL_RSTMASK];
      if (sequencer_irq_event)
        sequencer_stop_address <= sequencer_address;
    end
  end

  // APB read mux, sampled in the setup cycle
  always @* begin
    next_rdata = 32'h00000000;
    next_err   = 1'b0;
    case (paddr)
      `STER_OFS_CTRL:     next_rdata[3:0] = ctrl;
      `STER_OFS_STATUS:   next_rdata[`STER_NFLAGS-1:0] = flags;
      `STER_OFS_STOPADDR: next_rdata[7:0] = sequencer_stop_address;
      `STER_OFS_STATE:    next_rdata[9:0] = {halt_state, offset_count};
      `STER_OFS_COUNTCTL: next_rdata = 32'h00000000;
      default:            next_err = 1'b1;
    endcase
  end

  // Single wait-free access phase: pready rises the cycle after setup
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready     <= 1'b0;
      prdata     <= 32'h00000000;
      pslverr    <= 1'b0;
      ctrl       <= `STER_CTRL_RESET;
      pipe_flush <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      if (psel && !penable) begin
        prdata  <= pwrite ? 32'h00000000 : next_rdata;
        pslverr <= next_err;
      end else begin
        prdata  <= 32'h00000000;
        pslverr <= 1'b0;
      end
      if (wr && paddr == `STER_OFS_CTRL)
        ctrl <= pwdata[3:0];
      // Flushing needs both load bits in one write; the overrun flag is cleared separately
      pipe_flush <= wr && paddr == `STER_OFS_COUNTCTL &&
                    pwdata[`STER_CNT_LOAD] && pwdata[`STER_CNT_LATCH];
    end
  end
endmodule // ster_exception

//--- dv/ster_exception_properties.sv
// Port-level assertions for the exception block, bound into each instance.
// Assumes one pclk domain and write-one-to-clear status at the STATUS offset.
`timescale 1ns/1ps
`include "ster_regs.vh"
module ster_exception_properties (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pwrite,
  input wire logic       pready,
  input wire logic [7:0] paddr,
  input wire logic       byte_strobe,
  input wire logic       scsi_parity_err,
  input wire logic       dma_parity_err,
  input wire logic       dma_master,
  input wire logic       seq_running,
  input wire logic       stop_sequencer_event,
  input wire logic       count_overrun,
  input wire logic       bus_timeout_fault,
  input wire logic       selection_rejected,
  input wire logic       fifo_store,
  input wire logic       dma_request_en,
  input wire logic       seq_halt,
  input wire logic       scsi_tristate,
  input wire logic       high_level_regs_lock,
  input wire logic       sequencer_address_lock
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Flag clears at the write edge, the lock one edge later
  wire wr_st = psel && penable && pready && pwrite && paddr == `STER_OFS_STATUS;
  a_scsi_drop: assert property (byte_strobe && scsi_parity_err |=> !fifo_store) else $error("bad byte stored");
  a_dma_drop: assert property (byte_strobe && dma_parity_err |=> !fifo_store) else $error("bad dma byte");
  a_slave_drq: assert property (byte_strobe && dma_parity_err && !dma_master |-> ##2 !dma_request_en)
    else $error("request kept");
  a_parity_lock: assert property (byte_strobe && (scsi_parity_err || dma_parity_err) |-> ##2
    high_level_regs_lock && sequencer_address_lock) else $error("no lock on parity");
  a_stop_halt: assert property (stop_sequencer_event && seq_running |=> seq_halt) else $error("no halt");
  a_overrun_halt: assert property (count_overrun && seq_running |=> seq_halt) else $error("no halt");
  a_timeout_tri: assert property (bus_timeout_fault |-> ##2 scsi_tristate [*3]) else $error("no tristate");
  a_reject_run: assert property (selection_rejected |=> !seq_halt ##1 sequencer_address_lock)
    else $error("reject handling");
  a_lock_held: assert property ($fell(high_level_regs_lock) |-> $past(wr_st, 2)) else $error("lock dropped");
  c_halt: cover property (seq_halt);
  c_slave_fault: cover property (byte_strobe && dma_parity_err && !dma_master);
  c_unlock: cover property ($fell(high_level_regs_lock));
endmodule // ster_exception_properties
bind ster_exception ster_exception_properties i_chk (.*);

//--- dv/ster_initiator_model.sv
// Behavioural SCSI initiator driving the ATN, ACK and RST levels.
// Assumes the bench calls its tasks; pins change just after pclk edges.
`timescale 1ns/1ps
module ster_initiator_model (
  input  wire logic pclk,
  output logic      atn,
  output logic      ack,
  output logic      rst
);
  initial {atn, ack, rst} = 3'h0;
  task automatic set_atn(input logic v);
    @(posedge pclk) atn <= v;
  endtask
  // Each pulse ends in an ACK negation edge; hold sets prompt or slow
  task automatic ack_pulse(input int n, input int hold);
    repeat (n) begin
      @(posedge pclk) ack <= 1;
      repeat (hold) @(posedge pclk);
      ack <= 0;
      repeat (hold) @(posedge pclk);
    end
  endtask
  task automatic bus_reset(input int hold);
    @(posedge pclk) rst <= 1;
    repeat (hold) @(posedge pclk);
    rst <= 0;
  endtask
endmodule // ster_initiator_model

//--- dv/ster_exception_bench.sv
// Directed bench for the SCSI target exception block.
// Assumes the initiator model owns the SCSI pins; APB answers with no wait states.
`timescale 1ns/1ps
`include "ster_regs.vh"
module ster_exception_bench;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [7:0]  paddr = 0, sequencer_address = 8'h5A;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [17:0] ev = 0;
  logic        byte_strobe = 0, scsi_parity_err = 0, dma_parity_err = 0, dma_master = 0, sync_mode = 0;
  logic        fifo_xfer = 0, data_phase = 0, req_pulse = 0, seq_running = 0, instr_end = 0;
  // Tied: FIFO fill and direction lie outside these tests; t_events raises fifo_xfer_active
  logic        xfer_out = 0, fifo_empty = 1, fifo_xfer_active = 0, count_zero = 0;
  logic        pready, pslverr, scsi_atn_pin, scsi_ack_pin, scsi_rst_pin, fifo_store, dma_request_en;
  logic        req_stop, dma_stop, drain_dma, dpr_store, high_level_regs_clear, high_level_regs_lock;
  logic        sequencer_address_lock, low_level_regs_clear, seq_halt, xfer_halt, dma_halt, scsi_tristate;
  logic        busy_clear, pipe_shift_block, pipe_flush, irq_out, reset_flag_out;
  int          err_count = 0, compares = 0, cycles = 0;
  ster_exception i_dut (.*, .sequencer_irq_event(ev[2]), .stop_sequencer_event(ev[3]), .pipe_busy_event(ev[4]),
    .pipe_very_busy_event(ev[5]), .count_overrun(ev[6]), .bus_timeout_fault(ev[7]), .link_check_error(ev[8]),
    .count_underrun(ev[9]), .offset_error(ev[10]), .queue_error(ev[11]), .unexpected_selection(ev[12]),
    .unexpected_reselection(ev[13]), .unexpected_phase(ev[14]), .selection_rejected(ev[16]),
    .unexpected_disconnect(ev[17]));
  ster_initiator_model i_init (.pclk(pclk), .atn(scsi_atn_pin), .ack(scsi_ack_pin), .rst(scsi_rst_pin));
  always #12.5 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      summarize();
    end
  end
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    {rd, err} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask
  // Reads status, compares, then clears whatever was read
  task automatic st_is(input logic [31:0] e);
    repeat (6) @(posedge pclk);
    apb(0, `STER_OFS_STATUS, 0);
    chk("status", rd, e);
    apb(1, `STER_OFS_STATUS, rd);
  endtask
  task automatic strobe(input logic sp, input logic dp, input logic e);
    @(posedge pclk) {byte_strobe, scsi_parity_err, dma_parity_err} <= {1'b1, sp, dp};
    @(posedge pclk) {byte_strobe, scsi_parity_err, dma_parity_err} <= 3'h0;
    @(negedge pclk) chk("fifo_store", fifo_store, e);
  endtask
  task automatic end_instr();
    repeat (4) @(posedge pclk);
    instr_end <= 1;
    @(posedge pclk) instr_end <= 0;
  endtask
  task automatic t_apb();
    apb(0, `STER_OFS_CTRL, 0);
    chk("ctrl", rd, 0);
    apb(0, 8'h40, 0);
    chk("slverr", {err, rd[30:0]}, 32'h80000000);
    apb(1, `STER_OFS_COUNTCTL, 3);
    @(negedge pclk) chk("flush", pipe_flush, 1);
    apb(1, `STER_OFS_COUNTCTL, 1);
    @(negedge pclk) chk("flush", pipe_flush, 0);
  endtask
  task automatic t_parity();
    @(negedge pclk) chk("drq", dma_request_en, 1);
    strobe(0, 0, 1);
    strobe(0, 1, 0);
    strobe(0, 0, 0);
    chk("drq", dma_request_en, 0);
    st_is(1);
    dma_master <= 1;
    strobe(0, 1, 0);
    strobe(0, 0, 0);
    st_is(1);
    {dma_master, sync_mode} <= 2'b01;
    repeat (2) begin
      @(posedge pclk) req_pulse <= 1;
      @(posedge pclk) req_pulse <= 0;
    end
    strobe(1, 0, 0);
    i_init.ack_pulse(1, 2);
    st_is(1);
    apb(0, `STER_OFS_STATE, 0);
    chk("offset", rd[7:0], 8'h01);
    sync_mode <= 0;
  endtask
  task automatic t_events();
    logic [17:0] halts;
    halts = `STER_FAULT_MASK | 18'h00048;
    seq_running <= 1;
    fifo_xfer_active <= 1;
    for (int b = 2; b < 18; b++) begin
      if (b == `STER_F_BUSRST) continue;
      // A fresh address per event shows that only the interrupt event captures it
      @(posedge pclk) {ev[b], sequencer_address} <= {1'b1, 8'(b)};
      @(posedge pclk) ev[b] <= 0;
      @(negedge pclk) chk("halts", {seq_halt, xfer_halt, busy_clear, low_level_regs_clear},
        {halts[b], halts[b] && b > 6, b == 6, b == 17});
      repeat (4) @(negedge pclk);
      chk("locks", {high_level_regs_clear, high_level_regs_lock, sequencer_address_lock, scsi_tristate,
        pipe_shift_block}, {3'h7, b == 7 || b == 17, b == 6});
      apb(0, `STER_OFS_STOPADDR, 0);
      chk("stopaddr", rd, 32'h2);
      st_is(32'h1 << b);
      repeat (2) @(negedge pclk);
      chk("unlock", high_level_regs_lock, 0);
    end
  endtask
  task automatic t_attn();
    apb(1, `STER_OFS_CTRL, 0);
    {seq_running, data_phase} <= 2'b11;
    i_init.set_atn(1);
    end_instr();
    st_is(0);
    i_init.set_atn(0);
    seq_running <= 0;
    i_init.set_atn(1);
    repeat (6) @(negedge pclk);
    chk("hlr clear", high_level_regs_clear, 1);
    st_is(2);
    st_is(0);
    apb(1, `STER_OFS_CTRL, 1);
    seq_running <= 1;
    end_instr();
    st_is(2);
    apb(1, `STER_OFS_CTRL, 3);
    i_init.ack_pulse(1, 3);
    repeat (4) @(negedge pclk);
    chk("req_stop", req_stop, 1);
    st_is(2);
    apb(1, `STER_OFS_CTRL, 5);
    i_init.ack_pulse(1, 2);
    strobe(0, 0, 0);
    apb(1, `STER_OFS_CTRL, 0);
  endtask
  task automatic t_reset();
    i_init.bus_reset(3);
    @(negedge pclk) chk("rst pulse", {dma_halt, low_level_regs_clear}, 2'h3);
    repeat (5) @(negedge pclk);
    chk("rst outs", {reset_flag_out, irq_out, scsi_tristate, sequencer_address_lock,
      dma_request_en}, 5'h1C);
    st_is(32'h8000);
    apb(1, `STER_OFS_CTRL, 8);
    i_init.bus_reset(3);
    repeat (6) @(negedge pclk);
    chk("masked", {reset_flag_out, irq_out, scsi_tristate}, 3'h1);
    st_is(32'h8000);
  endtask
  task automatic summarize();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    t_apb();
    t_parity();
    t_events();
    t_attn();
    t_reset();
    summarize();
  end
endmodule // ster_exception_bench
